// ---- src/adc_control.sv ----
// Register file, prescaler, trigger and conversion sequencing for the converter
//
// Added by the designer: the register offsets and the strobed register port.
module adc_control (
  input  wire logic                          clock,
  input  wire logic                          resetn,
  input  wire logic [adc_pkg::ADDR_W-1:0]    addr,
  input  wire logic [adc_pkg::DATA_W-1:0]    wdata,
  input  wire logic                          wr_en,
  input  wire logic                          rd_en,
  output logic      [adc_pkg::DATA_W-1:0]    rdata,
  input  wire logic [7:0]                    trigger_sources,
  input  wire logic                          irq_ack,
  input  wire logic                          comparator_high,
  output logic                               converter_power,
  output logic      [1:0]                    reference_select,
  output logic                               reference_output_enable,
  output logic                               external_reference_enable,
  output logic                               current_source_enable,
  output logic      [adc_pkg::CHAN_W-1:0]    mux_select,
  output logic                               gain_bypass,
  output logic                               gain_20x,
  output logic                               temp_sensor_select,
  output logic                               current_source_route,
  output logic                               sample_hold,
  output logic      [adc_pkg::RES_W-1:0]     dac_code,
  output logic                               complete_irq
);
  typedef enum logic [1:0] {IDLE, WAIT_EDGE, CONVERT} conv_state_e;

  conv_state_e                       state_q;
  logic                              enable_q;
  logic                              auto_q;
  logic                              ie_q;
  logic [adc_pkg::A_PS_W-1:0]        ps_sel_q;
  logic [adc_pkg::TS_W-1:0]          ts_q;
  logic [adc_pkg::CHAN_W-1:0]        chan_q;
  logic                              left_q;
  logic [1:0]                        refs_q;
  logic [adc_pkg::MISC_W-1:0]        misc_q;
  logic                              flag_q;
  logic                              lock_q;
  logic                              first_q;
  logic                              trig_prev_q;
  logic [adc_pkg::RES_W-1:0]         result_q;
  logic [adc_pkg::PS_W-1:0]          ps_cnt_q;
  logic [adc_pkg::HC_W-1:0]          hcount_q;
  logic [adc_pkg::HC_W-1:0]          len_q;
  logic [adc_pkg::HC_W-1:0]          sh_q;
  logic [adc_pkg::CHAN_W-1:0]        chan_active_q;
  logic [1:0]                        refs_active_q;
  logic [adc_pkg::DATA_W-1:0]        rdata_q;
  logic                              comp_meta_q;
  logic                              comp_sync_q;

  logic                              wr_a;
  logic                              start_wr;
  logic [adc_pkg::A_PS_W-1:0]        ps_eff;
  logic [adc_pkg::PS_W-1:0]          ps_top;
  logic [adc_pkg::PS_W-1:0]          ps_mid;
  logic                              half_tick;
  logic                              full_tick;
  logic                              trig_level;
  logic                              trig_fire;
  logic                              begin_single;
  logic                              complete;
  logic                              free_run;
  logic                              sel_open;

  sar_if sar ();

  sar_core u_sar (
    .clock  (clock),
    .resetn (resetn),
    .bus    (sar)
  );

  assign wr_a     = wr_en && addr == adc_pkg::OFF_CTRL_A;
  assign start_wr = wr_a && wdata[adc_pkg::A_START];

  // Comparator comes from the analog core, so it crosses two flops first
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      comp_meta_q <= 1'b0;
      comp_sync_q <= 1'b0;
    end else begin
      comp_meta_q <= comparator_high;
      comp_sync_q <= comp_meta_q;
    end
  end

  // Control A and B writes; everything clears at reset R26
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      enable_q <= 1'b0;
      auto_q   <= 1'b0;
      ie_q     <= 1'b0;
      ps_sel_q <= '0;
      ts_q     <= '0;
    end else begin
      if (wr_a) begin
        enable_q <= wdata[adc_pkg::A_ENABLE];
        auto_q   <= wdata[adc_pkg::A_AUTO]; // R16
        ie_q     <= wdata[adc_pkg::A_IE];
        ps_sel_q <= wdata[adc_pkg::A_PS_LSB +: adc_pkg::A_PS_W];
      end
      if (wr_en && addr == adc_pkg::OFF_CTRL_B) begin
        ts_q <= wdata[adc_pkg::B_TS_LSB +: adc_pkg::TS_W]; // R16
      end
    end
  end

  // Channel select and analog control registers R26
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      chan_q <= '0;
      left_q <= 1'b0;
      refs_q <= '0;
      misc_q <= '0;
    end else begin
      if (wr_en && addr == adc_pkg::OFF_CHANNEL) begin
        chan_q <= wdata[adc_pkg::CH_MUX_LSB +: adc_pkg::CHAN_W];
        left_q <= wdata[adc_pkg::CH_LEFT]; // R10
        refs_q <= wdata[adc_pkg::CH_REFS_LSB +: 2];
      end
      if (wr_en && addr == adc_pkg::OFF_MISC) begin
        misc_q <= wdata[adc_pkg::MISC_W-1:0];
      end
    end
  end

  // Division of 2 for codes 0 and 1, else 2 to the power of the code
  assign ps_eff    = (ps_sel_q == '0) ? adc_pkg::A_PS_W'(1) : ps_sel_q;
  assign ps_top    = adc_pkg::PS_W'((8'h01 << ps_eff) - 8'h01);
  assign ps_mid    = ps_top >> 1;
  assign half_tick = enable_q && (ps_cnt_q == ps_mid || ps_cnt_q == ps_top);
  assign full_tick = enable_q && ps_cnt_q == ps_top;

  // Prescaler held at zero while disabled, restarted by a trigger edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ps_cnt_q <= '0;
    end else if (!enable_q || trig_fire) begin
      ps_cnt_q <= '0; // R24 R17
    end else if (ps_cnt_q == ps_top) begin
      ps_cnt_q <= '0;
    end else begin
      ps_cnt_q <= ps_cnt_q + 1'b1;
    end
  end

  // Trigger sources are peripheral flags on this clock, so no synchroniser
  assign free_run   = auto_q && ts_q == adc_pkg::TS_FREE;
  assign trig_level = free_run ? 1'b0 : trigger_sources[ts_q]; // R19
  // Edges only count while idle; a level held through completion is no edge R18
  assign trig_fire  = enable_q && auto_q && state_q == IDLE && trig_level && !trig_prev_q; // R17

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_level;
    end
  end

  // A written start waits for the next converter clock edge R23
  assign begin_single = state_q == WAIT_EDGE && full_tick;
  assign complete     = state_q == CONVERT && half_tick && hcount_q == len_q - 1'b1;

  // Sequencer: start bit reads as any state other than idle R21
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q  <= IDLE;
      hcount_q <= '0;
      len_q    <= adc_pkg::LEN_NORMAL;
      sh_q     <= adc_pkg::SH_NORMAL;
    end else if (!enable_q) begin
      state_q  <= IDLE; // R8
      hcount_q <= '0;
    end else begin
      unique case (state_q)
        IDLE: begin
          if (trig_fire) begin
            state_q  <= CONVERT; // R17
            hcount_q <= '0;
            len_q    <= first_q ? adc_pkg::LEN_FIRST : adc_pkg::LEN_AUTO; // R22
            sh_q     <= first_q ? adc_pkg::SH_FIRST : adc_pkg::SH_AUTO;
          end else if (start_wr) begin
            state_q <= WAIT_EDGE; // R14 R21
          end
        end
        WAIT_EDGE: begin
          if (begin_single) begin
            state_q  <= CONVERT;
            hcount_q <= '0;
            len_q    <= first_q ? adc_pkg::LEN_FIRST : adc_pkg::LEN_NORMAL; // R22
            sh_q     <= first_q ? adc_pkg::SH_FIRST : adc_pkg::SH_NORMAL;
          end
        end
        CONVERT: begin
          if (complete) begin
            hcount_q <= '0;
            len_q    <= adc_pkg::LEN_NORMAL;
            sh_q     <= adc_pkg::SH_NORMAL;
            // Own completion retriggers at once, flag cleared or not R20
            state_q  <= free_run ? CONVERT : IDLE; // R14 R23
          end else if (half_tick) begin
            hcount_q <= hcount_q + 1'b1;
          end
        end
      endcase
    end
  end

  // Longer first conversion after each enable R22
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      first_q <= 1'b1;
    end else if (!enable_q) begin
      first_q <= 1'b1;
    end else if (trig_fire || begin_single) begin
      first_q <= 1'b0;
    end
  end

  // Approximation register is reset at each conversion start
  assign sar.clear    = trig_fire || begin_single || (complete && free_run);
  assign sar.step     = state_q == CONVERT && full_tick && hcount_q >= sh_q;
  assign sar.comp_bit = comp_sync_q;

  // Completion flag: set wins over a clear in the same cycle R13 R25
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      flag_q <= 1'b0;
    end else if (complete) begin
      flag_q <= 1'b1; // R13
    end else if ((wr_a && wdata[adc_pkg::A_FLAG]) || irq_ack) begin
      flag_q <= 1'b0; // R25
    end
  end

  // Low byte read blocks result updates until high byte read R12
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lock_q <= 1'b0;
    end else if (rd_en && addr == adc_pkg::OFF_RES_LO) begin
      lock_q <= 1'b1; // R12
    end else if (rd_en && addr == adc_pkg::OFF_RES_HI) begin
      lock_q <= 1'b0; // R12
    end
  end

  // Result written at completion unless blocked; a blocked one is lost
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      result_q <= '0;
    end else if (complete && !lock_q) begin
      result_q <= sar.code; // R3 R12 R23
    end
  end

  // Selections follow the register until a conversion locks them,
  // reopening in its last converter cycle so the next one sees them R15
  assign sel_open = state_q != CONVERT || hcount_q >= len_q - adc_pkg::LAST_HALVES;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      chan_active_q <= '0;
      refs_active_q <= '0;
    end else if (enable_q && sel_open) begin
      chan_active_q <= chan_q; // R8 R15
      refs_active_q <= refs_q; // R4
    end
  end

  // Read data appear the cycle after the read strobe; unmapped reads as zero
  // Alignment applies at read time, so left adjust needs no new conversion
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= adc_pkg::RESET_BYTE;
    end else if (rd_en) begin
      unique case (addr)
        adc_pkg::OFF_CTRL_A:  rdata_q <= {enable_q, state_q != IDLE, auto_q, flag_q, ie_q, ps_sel_q}; // R21
        adc_pkg::OFF_CTRL_B:  rdata_q <= {{(adc_pkg::DATA_W-adc_pkg::TS_W){1'b0}}, ts_q};
        adc_pkg::OFF_CHANNEL: rdata_q <= {refs_q, left_q, chan_q};
        adc_pkg::OFF_RES_LO:  rdata_q <= left_q ? {result_q[1:0], 6'h00} : result_q[7:0]; // R10
        adc_pkg::OFF_RES_HI:  rdata_q <= left_q ? result_q[9:2] : {6'h00, result_q[9:8]}; // R10
        adc_pkg::OFF_MISC:    rdata_q <= {{(adc_pkg::DATA_W-adc_pkg::MISC_W){1'b0}}, misc_q};
        default:              rdata_q <= adc_pkg::RESET_BYTE;
      endcase
    end
  end

  assign rdata = rdata_q;

  // Analog controls; the current source runs independently of the converter
  assign converter_power           = enable_q; // R8
  assign reference_select          = refs_active_q; // R4
  assign reference_output_enable   = misc_q[adc_pkg::MISC_EXTERNAL_REFERENCE_PIN]; // R4
  assign external_reference_enable = misc_q[adc_pkg::MISC_XREF]; // R4
  assign current_source_enable     = misc_q[adc_pkg::MISC_CSRC]; // R1

  // Channel decode: pins, internal sources, and gain pairs R5 R6 R7
  assign mux_select           = chan_active_q; // R6
  assign gain_bypass          = chan_active_q < adc_pkg::CH_DIFF_LO; // R5
  assign gain_20x             = !gain_bypass && chan_active_q[adc_pkg::CH_GAIN_BIT]; // R5
  assign temp_sensor_select   = chan_active_q == adc_pkg::CH_TEMP; // R7
  assign current_source_route = chan_active_q == adc_pkg::CH_INTERNAL_CURRENT_SOURCE; // R7

  assign sample_hold  = state_q == CONVERT && hcount_q < sh_q;
  assign dac_code     = sar.code;
  assign complete_irq = flag_q && ie_q;
endmodule

// ---- src/adc_pkg.sv ----
// Constants, register map and timing for the converter control block
// Overview of operation
// R1: Bit 0 of the analog control register switches the internal current source on or off.
// R2: Software disables the digital input buffer while the source runs, then turns it off.
// R3: Successive approximation yields a 10-bit code from ground up to the reference.
// R4: Reference comes from the select field plus reference output and external enables.
// R5: Channel field picks input; single-ended bypasses gain, differential pairs get 8x or 20x.
// R6: Each of the eleven analog pins can be chosen as a single-ended input.
// R7: Dedicated channel codes route the temperature sensor or current source voltage.
// R8: Converter works only when enabled; selections take effect only then.
// R9: Software clears the converter enable before sleep.
// R10: Result is right-aligned by default, left-aligned when left adjust is set.
// R11: Software reads low byte before high byte, or high byte alone when left-aligned.
// R12: Reading low byte blocks updates until high byte read; blocked results are lost.
// R13: Completion flag rises on every completion, even when the result was lost.
// R14: Writing start begins one conversion; start stays set until hardware clears it.
// R15: A channel change mid-conversion applies only after that conversion ends.
// R16: Auto-trigger enable starts conversions from the source picked by trigger select.
// R17: Rising trigger edge resets the prescaler and starts a conversion.
// R18: Trigger still high at completion or edges during conversion start nothing.
// R19: Trigger flags set regardless of interrupt enables; software clears them before reuse.
// R20: With own completion as trigger, conversions run back to back; first via start.
// R21: Start still works in auto mode and reads one during any conversion.
// R22: Conversions take 13 clock cycles, 25 for the first, 13.5 when auto-triggered.
// R23: Completion writes result, sets flag, clears start; a new start waits for next edge.
// R24: Prescaler counts only while enabled and is held reset otherwise.
// R25: Completion flag clears on a written one or on interrupt handler entry.
// R26: All control bits reset to zero: disabled, single mode, right-aligned.
package adc_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int RES_W  = 10;
  localparam int CHAN_W = 5;
  localparam int PS_W   = 7;
  localparam int HC_W   = 6;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL_A  = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_CTRL_B  = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_CHANNEL = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_RES_LO  = 3'h3;
  localparam logic [ADDR_W-1:0] OFF_RES_HI  = 3'h4;
  localparam logic [ADDR_W-1:0] OFF_MISC    = 3'h5;

  // Control A fields
  localparam int A_ENABLE = 7;
  localparam int A_START  = 6;
  localparam int A_AUTO   = 5;
  localparam int A_FLAG   = 4;
  localparam int A_IE     = 3;
  localparam int A_PS_LSB = 0;
  localparam int A_PS_W   = 3;

  // Control B, channel select and analog control fields
  localparam int B_TS_LSB    = 0;
  localparam int TS_W        = 3;
  localparam logic [TS_W-1:0] TS_FREE = 3'h0;
  localparam int CH_MUX_LSB  = 0;
  localparam int CH_LEFT     = 5;
  localparam int CH_REFS_LSB = 6;
  localparam int MISC_CSRC   = 0;
  localparam int MISC_XREF   = 1;
  localparam int MISC_EXTERNAL_REFERENCE_PIN   = 2;
  localparam int MISC_W      = 3;

  localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;

  // Channel codes: 0..10 single-ended pins, then internal sources, then differential
  localparam logic [CHAN_W-1:0] CH_SE_LAST = 5'h0A;
  localparam logic [CHAN_W-1:0] CH_TEMP    = 5'h0B;
  localparam logic [CHAN_W-1:0] CH_INTERNAL_CURRENT_SOURCE    = 5'h0C;
  localparam logic [CHAN_W-1:0] CH_DIFF_LO = 5'h10;
  localparam int CH_GAIN_BIT = 0;

  // Timing in converter clock cycles, held as half-cycle counts
  localparam int NORMAL_CYCLES = 13;
  localparam int FIRST_CYCLES  = 25;
  localparam int AUTO_HALVES   = 27;
  localparam logic [HC_W-1:0] LEN_NORMAL = HC_W'(2 * NORMAL_CYCLES);
  localparam logic [HC_W-1:0] LEN_FIRST  = HC_W'(2 * FIRST_CYCLES);
  localparam logic [HC_W-1:0] LEN_AUTO   = HC_W'(AUTO_HALVES);
  localparam logic [HC_W-1:0] SH_NORMAL  = 6'h03;
  localparam logic [HC_W-1:0] SH_FIRST   = 6'h1B;
  localparam logic [HC_W-1:0] SH_AUTO    = 6'h04;
  localparam logic [HC_W-1:0] LAST_HALVES = 6'h02;
  localparam logic [RES_W-1:0] SAR_MID   = 10'h200;
endpackage

// ---- src/sar_if.sv ----
// Handshake between conversion sequencer and approximation register
interface sar_if;
  logic                         clear;
  logic                         step;
  logic                         comp_bit;
  logic [adc_pkg::RES_W-1:0]    code;

  modport ctrl (output clear, output step, output comp_bit, input code);
  modport core (input clear, input step, input comp_bit, output code);
endinterface

// ---- src/sar_core.sv ----
// Successive approximation register, one bit decided per step
module sar_core (
  input  wire logic clock,
  input  wire logic resetn,
  sar_if.core       bus
);
  logic [adc_pkg::RES_W-1:0] code_q;
  logic [adc_pkg::RES_W-1:0] trial_q;

  // Trial bit walks from the MSB down; steps after the LSB are ignored
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      code_q  <= '0;
      trial_q <= '0;
    end else if (bus.clear) begin
      code_q  <= adc_pkg::SAR_MID;
      trial_q <= adc_pkg::SAR_MID;
    end else if (bus.step && trial_q != '0) begin
      // Keep the bit when the input is above the DAC level R3
      code_q  <= (bus.comp_bit ? code_q : (code_q & ~trial_q)) | (trial_q >> 1);
      trial_q <= trial_q >> 1;
    end
  end

  assign bus.code = code_q;
endmodule

// ---- bench/adc_control_asserts.sv ----
// Concurrent port checks for the converter control block
module adc_control_asserts (
  input wire logic                       clock,
  input wire logic                       resetn,
  input wire logic [adc_pkg::ADDR_W-1:0] addr,
  input wire logic [adc_pkg::DATA_W-1:0] wdata,
  input wire logic                       wr_en,
  input wire logic                       rd_en,
  input wire logic [adc_pkg::DATA_W-1:0] rdata,
  input wire logic                       irq_ack,
  input wire logic                       converter_power,
  input wire logic [1:0]                 reference_select,
  input wire logic                       reference_output_enable,
  input wire logic                       external_reference_enable,
  input wire logic                       current_source_enable,
  input wire logic [adc_pkg::CHAN_W-1:0] mux_select,
  input wire logic                       gain_bypass,
  input wire logic                       gain_20x,
  input wire logic                       temp_sensor_select,
  input wire logic                       current_source_route,
  input wire logic                       sample_hold,
  input wire logic                       complete_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so clocking and reset are stated once
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  AST_POWER_FOLLOWS: assert property (wr_en && addr == adc_pkg::OFF_CTRL_A |=>
    converter_power == $past(wdata[adc_pkg::A_ENABLE])) else $error("power does not follow enable bit");
  AST_MISC_BITS: assert property (wr_en && addr == adc_pkg::OFF_MISC |=>
    {reference_output_enable, external_reference_enable, current_source_enable} == $past(wdata[2:0]))
    else $error("analog control outputs do not follow write");
  AST_MISC_READ: assert property (rd_en && addr == adc_pkg::OFF_MISC |=>
    rdata == {5'h00, reference_output_enable, external_reference_enable, current_source_enable})
    else $error("analog control readback wrong");
  AST_GAIN_PATH: assert property ((gain_bypass == (mux_select < adc_pkg::CH_DIFF_LO)) &&
    (gain_20x == (!gain_bypass && mux_select[adc_pkg::CH_GAIN_BIT]))) else $error("gain path decode wrong");
  AST_INTERNAL_SRC: assert property ((temp_sensor_select == (mux_select == adc_pkg::CH_TEMP)) &&
    (current_source_route == (mux_select == adc_pkg::CH_INTERNAL_CURRENT_SOURCE))) else $error("internal source decode wrong");
  AST_SEL_LOCKED: assert property (sample_hold && $past(sample_hold) |->
    $stable(mux_select) && $stable(reference_select)) else $error("selection moved while sampling");
  AST_SEL_GATED: assert property (!converter_power ##1 !converter_power |->
    $stable(mux_select) && $stable(reference_select)) else $error("selection moved while disabled");
  AST_IDLE_POWER: assert property (!converter_power ##1 !converter_power |-> !sample_hold)
    else $error("sampling while disabled");
  AST_BUSY_READ: assert property (rd_en && addr == adc_pkg::OFF_CTRL_A && sample_hold |=>
    rdata[adc_pkg::A_START]) else $error("start bit low during conversion");
  AST_IRQ_LEVEL: assert property (rd_en && addr == adc_pkg::OFF_CTRL_A && complete_irq && !irq_ack |=>
    rdata[adc_pkg::A_FLAG] && rdata[adc_pkg::A_IE]) else $error("interrupt without flag and enable");

  // Main scenarios reached
  cover property ($rose(complete_irq));
  cover property ($rose(sample_hold));
  cover property (gain_20x);
  cover property (rd_en && addr == adc_pkg::OFF_RES_HI);
endmodule

// ---- bench/sar_adc_conversion_control_bench.sv ----
// Self-checking bench for the converter control block
module sar_adc_conversion_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       clock, resetn, wr_en, rd_en, irq_ack, comparator_high;
  logic [adc_pkg::ADDR_W-1:0] addr;
  logic [adc_pkg::DATA_W-1:0] wdata, rdata, d;
  logic [7:0]                 trigger_sources;
  logic                       converter_power, reference_output_enable, external_reference_enable;
  logic                       current_source_enable, gain_bypass, gain_20x, temp_sensor_select;
  logic                       current_source_route, sample_hold, complete_irq, left;
  logic [1:0]                 reference_select;
  logic [adc_pkg::CHAN_W-1:0] mux_select, c;
  logic [adc_pkg::RES_W-1:0]  dac_code, vin;
  logic [15:0]                exp;
  logic [4:0]                 codes [8] = '{5'h00, 5'h05, 5'h0A, 5'h0B, 5'h0C, 5'h10, 5'h11, 5'h1F};
  int                         error_cnt, num_checks, seed;

  adc_control i_adc_control (.*);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Analog input sits half a step above vin, so the trial code vin is kept
  always @(posedge clock) begin
    comparator_high <= (vin >= dac_code);
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] e);
    num_checks++;
    if (seen !== e) begin
      error_cnt++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, e);
    end
  endtask

  task automatic finish_test();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic wr(input logic [adc_pkg::ADDR_W-1:0] a, input logic [7:0] v);
    @(posedge clock);
    addr  <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  // Read data appears the cycle after the strobe and holds until the next read strobe
  task automatic rd_chk(input logic [adc_pkg::ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    check(16'(rdata), 16'(e));
  endtask

  // Bounded wait: a hung sequencer shows up as a mismatch, not a stall
  task automatic wait_irq();
    int n;
    n = 0;
    while (complete_irq !== 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    check(16'(complete_irq), 16'h0001);
  endtask

  // Expected {high, low} bytes for a code and alignment
  function automatic logic [15:0] exp_res(input logic [9:0] v, input logic lft);
    return lft ? {v[9:2], v[1:0], 6'h00} : {6'h00, v};
  endfunction

  initial begin
    #500000;
    error_cnt++;
    finish_test();
  end

  initial begin
    seed = 32'hf8ee407c;
    error_cnt = 0;
    num_checks = 0;
    resetn = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    irq_ack = 1'b0;
    trigger_sources = 8'h00;
    vin = 10'h000;
    comparator_high = 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    for (int a = 0; a < 8; a++) rd_chk(3'(a), 8'h00);
    repeat (4) begin
      d = 8'($random(seed));
      wr(adc_pkg::OFF_MISC, d);
      rd_chk(adc_pkg::OFF_MISC, {5'h00, d[2:0]});
      check(16'({reference_output_enable, external_reference_enable, current_source_enable}), 16'(d[2:0]));
    end
    // Selections must wait for the enable bit
    wr(adc_pkg::OFF_CHANNEL, 8'hCB);
    tick(2);
    check(16'({converter_power, reference_select, mux_select}), 16'h0000);
    rd_chk(adc_pkg::OFF_CHANNEL, 8'hCB);
    wr(adc_pkg::OFF_CTRL_A, 8'h8C);
    tick(2);
    check(16'({converter_power, reference_select, mux_select}), 16'h00EB);
    foreach (codes[i]) begin
      c = codes[i];
      wr(adc_pkg::OFF_CHANNEL, {3'h0, c});
      tick(2);
      check(16'({mux_select, gain_bypass, gain_20x, temp_sensor_select, current_source_route}),
            16'({c, c < 5'h10, c >= 5'h10 && c[0], c == 5'h0B, c == 5'h0C}));
    end
    // Single conversions, both alignments, boundary codes
    for (int i = 0; i < 4; i++) begin
      left = i[0];
      vin = (i == 2) ? 10'h000 : (i == 3) ? 10'h3FF : 10'($random(seed));
      wr(adc_pkg::OFF_CHANNEL, {2'h0, left, 5'h01});
      wr(adc_pkg::OFF_CTRL_A, 8'hCC);
      rd_chk(adc_pkg::OFF_CTRL_A, 8'hCC);
      tick(20);
      wr(adc_pkg::OFF_CHANNEL, {2'h0, left, 5'h02});
      tick(1);
      check(16'(mux_select), 16'h0001);
      wait_irq();
      rd_chk(adc_pkg::OFF_CTRL_A, 8'h9C);
      check(16'(mux_select), 16'h0002);
      exp = exp_res(vin, left);
      rd_chk(adc_pkg::OFF_RES_LO, exp[7:0]);
      rd_chk(adc_pkg::OFF_RES_HI, exp[15:8]);
      if (left) begin
        wr(adc_pkg::OFF_CTRL_A, 8'h9C);
      end else begin
        @(posedge clock) irq_ack <= 1'b1;
        @(posedge clock) irq_ack <= 1'b0;
      end
      tick(1);
      check(16'(complete_irq), 16'h0000);
    end
    // Low byte read holds the pair until the high byte is read
    vin = 10'h155;
    wr(adc_pkg::OFF_CHANNEL, 8'h01);
    wr(adc_pkg::OFF_CTRL_A, 8'hCC);
    wait_irq();
    wr(adc_pkg::OFF_CTRL_A, 8'h9C);
    rd_chk(adc_pkg::OFF_RES_LO, 8'h55);
    vin = 10'h2AA;
    wr(adc_pkg::OFF_CTRL_A, 8'hCC);
    wait_irq();
    rd_chk(adc_pkg::OFF_RES_HI, 8'h01);
    rd_chk(adc_pkg::OFF_RES_LO, 8'h55);
    rd_chk(adc_pkg::OFF_RES_HI, 8'h01);
    wr(adc_pkg::OFF_CTRL_A, 8'h9C);
    wr(adc_pkg::OFF_CTRL_A, 8'hCC);
    wait_irq();
    rd_chk(adc_pkg::OFF_RES_LO, 8'hAA);
    rd_chk(adc_pkg::OFF_RES_HI, 8'h02);
    // Edge trigger: held level and mid-conversion edges start nothing more
    wr(adc_pkg::OFF_CTRL_A, 8'h9C);
    wr(adc_pkg::OFF_CTRL_B, 8'h03);
    rd_chk(adc_pkg::OFF_CTRL_B, 8'h03);
    wr(adc_pkg::OFF_CTRL_A, 8'hAC);
    @(posedge clock) trigger_sources[3] <= 1'b1;
    tick(3);
    rd_chk(adc_pkg::OFF_CTRL_A, 8'hEC);
    @(posedge clock) trigger_sources[3] <= 1'b0;
    tick(4);
    @(posedge clock) trigger_sources[3] <= 1'b1;
    wait_irq();
    wr(adc_pkg::OFF_CTRL_A, 8'hBC);
    tick(600);
    rd_chk(adc_pkg::OFF_CTRL_A, 8'hAC);
    wr(adc_pkg::OFF_CTRL_A, 8'hEC);
    wait_irq();
    rd_chk(adc_pkg::OFF_CTRL_A, 8'hBC);
    // Free running on own completion, first start by software
    @(posedge clock) trigger_sources[3] <= 1'b0;
    wr(adc_pkg::OFF_CTRL_B, 8'h00);
    wr(adc_pkg::OFF_CTRL_A, 8'hBC);
    tick(600);
    check(16'(complete_irq), 16'h0000);
    wr(adc_pkg::OFF_CTRL_A, 8'hEC);
    wait_irq();
    tick(20);
    rd_chk(adc_pkg::OFF_CTRL_A, 8'hFC);
    vin = 10'($random(seed));
    tick(600);
    exp = exp_res(vin, 1'b0);
    rd_chk(adc_pkg::OFF_RES_LO, exp[7:0]);
    rd_chk(adc_pkg::OFF_RES_HI, exp[15:8]);
    wr(adc_pkg::OFF_CTRL_A, 8'h00);
    tick(2);
    check(16'({converter_power, sample_hold}), 16'h0000);
    finish_test();
  end
endmodule

bind adc_control adc_control_asserts i_adc_control_asserts (.*);
